// file: hw/fec_pkg.sv
package fec_pkg;
    // Opcodes
    localparam logic [7:0] OP_SECTOR_ERASE_A  = 8'hD7;
    localparam logic [7:0] OP_SECTOR_ERASE_B  = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE_W  = 8'h21;
    localparam logic [7:0] OP_HALF_BLOCK      = 8'h52;
    localparam logic [7:0] OP_FULL_BLOCK      = 8'hD8;
    localparam logic [7:0] OP_HALF_BLOCK_W    = 8'h5C;
    localparam logic [7:0] OP_FULL_BLOCK_W    = 8'hDC;
    localparam logic [7:0] OP_CHIP_ERASE_A    = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B    = 8'h60;
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0] OP_STATUS_READ     = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
    localparam logic [7:0] OP_FUNC_READ       = 8'h48;
    localparam logic [7:0] OP_FUNC_WRITE      = 8'h42;
    localparam logic [7:0] OP_QUAD_ENTER      = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT       = 8'hF5;
    localparam logic [7:0] OP_EXT_READ_REG    = 8'h81;
    localparam logic [7:0] OP_SUSPEND_A       = 8'h75;
    localparam logic [7:0] OP_SUSPEND_B       = 8'hB0;
    localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
    localparam logic [7:0] OP_RESET_DO        = 8'h99;
    // Status register layout
    localparam int unsigned SR_WIP_BIT        = 0;
    localparam int unsigned SR_WEL_BIT        = 1;
    localparam int unsigned SR_BP_LSB         = 2;
    localparam int unsigned SR_QE_BIT         = 6;
    localparam int unsigned SR_STATUS_WRITE_PROTECT_BIT       = 7;
    localparam logic [7:0]  SR_WRITE_MASK     = 8'hFC;
    localparam logic [7:0]  SR_RESET          = 8'h00;
    // Function register: bit0 reset-pin disable, bits 7:4 info row locks
    localparam logic [7:0]  FR_OTP_MASK       = 8'hF1;
    localparam logic [7:0]  FR_RESET          = 8'h00;
    // Erase geometry, sizes in address bits
    localparam int unsigned SECTOR_SHIFT      = 12;
    localparam int unsigned HALF_BLOCK_SHIFT  = 15;
    localparam int unsigned FULL_BLOCK_SHIFT  = 16;
    localparam int unsigned NUM_SECTORS       = 8192;
    localparam int unsigned SECT_W            = 13;
    // Bytes on the link
    localparam logic [2:0]  ADDR3_BYTES       = 3'd3;
    localparam logic [2:0]  ADDR4_BYTES       = 3'd4;

    typedef enum logic [5:0] {
        FEC_IDLE   = 6'b00_0001,
        FEC_CHECK  = 6'b00_0010,
        FEC_ERASE  = 6'b00_0100,
        FEC_WAIT   = 6'b00_1000,
        FEC_DONE   = 6'b01_0000,
        FEC_REJECT = 6'b10_0000
    } fec_state_t;

    typedef enum logic [1:0] {
        KIND_SECTOR = 2'd0,
        KIND_HALF   = 2'd1,
        KIND_FULL   = 2'd2,
        KIND_CHIP   = 2'd3
    } fec_kind_t;

    // Erase request handed from link to core
    typedef struct packed {
        fec_kind_t   kind;
        logic [31:0] addr;
    } fec_req_t;
endpackage

// file: hw/fec_erase_cmds.sv
// Notes on behaviour
// - Sector erase D7h/20h use 3 or 4 address bytes; 21h always 4.
// - Sector erase sets one 4 KB sector to ones, others untouched.
// - Erase runs only when the write enable latch is set.
// - Write enable latch clears itself when any erase finishes.
// - Erase starts at chip select rise after full command, else discarded.
// - While erasing, only status, ext read reg, suspend, reset are taken; here only 05h and 48h reads answer, all else is dropped.
// - Write-in-progress reads 1 while erasing and 0 after completion.
// - Block erase 52h/D8h follow addressing mode; 5Ch/DCh always 4 bytes.
// - Chip erase C7h/60h has no address and erases every sector of the array not set in asp_protect_in.
// - Chip erase needs all protect bits zero, else sets both error flags.
// - Chip erase skips protected sectors silently without error flags.
// - Opcode 06h sets the write enable latch.
// - Write enable latch is clear after power-up.
// - Erase, status and function register writes need the latch set.
// - Opcode 04h clears the write enable latch.
// - Opcode 05h returns status, accepted even during an erase.
// - Opcode 01h writes protect bits, write-protect bit and quad enable.
// - Opcode 48h returns the function register.
// - Opcode 42h writes function register; OTP bits can only be set.
// - Opcode 35h enters four-wire command mode.
// - Opcode F5h leaves four-wire mode, only as a two-clock quad command.
// - In four-wire mode the opcode takes two clocks on four lines.
`timescale 1ns/1ps
`default_nettype none
module fec_erase_cmds
    import fec_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 5000
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 sck_in,
    input  wire logic                 cs_n_in,
    input  wire logic [3:0]           io_in,
    output logic      [3:0]           io_out,
    output logic      [3:0]           io_oe_out,
    input  wire logic                 extended_addressing_in,
    input  wire logic [NUM_SECTORS-1:0] asp_protect_in,
    output logic                      write_in_progress_out,
    output logic                      write_enable_latch_out,
    output logic                      four_wire_command_mode_out,
    output logic                      erase_error_flag_out,
    output logic                      protection_error_flag_out,
    output logic      [7:0]           status_reg_out,
    output logic      [7:0]           function_reg_out,
    output logic      [NUM_SECTORS-1:0] sector_blank_out
);
    // Link domain: shifts opcode/address/data on sck.
    // Cs high resets the link logic, so the frame ends with its own signal.
    logic [7:0]  sh_r;
    logic [2:0]  bitc_r;
    logic [3:0]  bytec_r;
    logic [7:0]  op_r;
    logic [31:0] addr_r;
    logic [7:0]  data_r;
    logic [7:0]  out_sh_r;
    logic [3:0]  io_l_r;
    logic [3:0]  oe_l_r;
    logic        quad_snap_r;
    logic        ext_snap_r;
    logic        quad_clk_r;
    logic        quad_s1_r;
    logic        quad_s2_r;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic [7:0]  sr_s1_r;
    logic [7:0]  sr_s2_r;
    logic [7:0]  fr_s1_r;
    logic [7:0]  fr_s2_r;

    function automatic logic [2:0] addr_len(input logic [7:0] op, input logic ext);
        addr_len = 3'd0;
        case (op)
            OP_SECTOR_ERASE_A, OP_SECTOR_ERASE_B,
            OP_HALF_BLOCK, OP_FULL_BLOCK:
                addr_len = ext ? ADDR4_BYTES : ADDR3_BYTES;
            OP_SECTOR_ERASE_W, OP_HALF_BLOCK_W, OP_FULL_BLOCK_W:
                addr_len = ADDR4_BYTES;
            default: addr_len = 3'd0;
        endcase
    endfunction

    // Settings from core cross into sck domain; sck runs only in frames,
    // so the frame right after a change still starts with the old four-wire and addressing values.
    always_ff @(posedge sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quad_s1_r <= 1'b0;
            quad_s2_r <= 1'b0;
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            sr_s1_r   <= SR_RESET;
            sr_s2_r   <= SR_RESET;
            fr_s1_r   <= FR_RESET;
            fr_s2_r   <= FR_RESET;
        end else begin
            quad_s1_r <= four_wire_command_mode_out;
            quad_s2_r <= quad_s1_r;
            ext_s1_r  <= extended_addressing_in;
            ext_s2_r  <= ext_s1_r;
            sr_s1_r   <= status_reg_out;
            sr_s2_r   <= sr_s1_r;
            fr_s1_r   <= function_reg_out;
            fr_s2_r   <= fr_s1_r;
        end
    end

    logic [7:0] sh_nxt;
    logic [2:0] step;
    always_comb begin
        step   = quad_clk_r ? 3'd4 : 3'd1;
        sh_nxt = quad_clk_r ? {sh_r[3:0], io_in} : {sh_r[6:0], io_in[0]};
    end

    // Frame-scope shifter, asynchronously cleared while cs is high
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            sh_r        <= 8'h00;
            bitc_r      <= 3'd0;
            bytec_r     <= 4'd0;
            op_r        <= 8'h00;
            addr_r      <= 32'h0000_0000;
            data_r      <= 8'h00;
            quad_clk_r  <= 1'b0;
            quad_snap_r <= 1'b0;
            ext_snap_r  <= 1'b0;
        end else begin
            if (bytec_r == 4'd0 && bitc_r == 3'd0) begin
                quad_clk_r  <= quad_s2_r;
                quad_snap_r <= quad_s2_r;
                ext_snap_r  <= ext_s2_r;
                sh_r        <= quad_s2_r ? {4'h0, io_in} : {7'h00, io_in[0]};
                bitc_r      <= quad_s2_r ? 3'd4 : 3'd1;
            end else begin
                sh_r   <= sh_nxt;
                bitc_r <= bitc_r + step;
            end
            if (bitc_r + step == 3'd0 && !(bytec_r == 4'd0 && bitc_r == 3'd0)) begin
                bytec_r <= (bytec_r == 4'd15) ? bytec_r : bytec_r + 4'd1;
                if (bytec_r == 4'd0) begin
                    op_r <= sh_nxt;
                end else if (bytec_r <= 4'(addr_len(op_r, ext_snap_r))) begin
                    addr_r <= {addr_r[23:0], sh_nxt};
                end else if (bytec_r == 4'd1) begin
                    data_r      <= sh_nxt;
                end
            end
        end
    end

    // Reply shifter on falling edge for the reading commands
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            out_sh_r <= 8'h00;
            io_l_r   <= 4'h0;
            oe_l_r   <= 4'h0;
        end else if (bytec_r >= 4'd1 &&
                     (op_r == OP_STATUS_READ || op_r == OP_FUNC_READ)) begin
            if (bitc_r == 3'd0) begin
                out_sh_r <= (op_r == OP_STATUS_READ) ? sr_s2_r : fr_s2_r;
                io_l_r   <= quad_snap_r
                    ? ((op_r == OP_STATUS_READ) ? sr_s2_r[7:4] : fr_s2_r[7:4])
                    : {2'b00, ((op_r == OP_STATUS_READ) ? sr_s2_r[7] : fr_s2_r[7]), 1'b0};
            end else begin
                io_l_r   <= quad_snap_r ? out_sh_r[3:0]
                                        : {2'b00, out_sh_r[7 - bitc_r], 1'b0};
            end
            oe_l_r   <= quad_snap_r ? 4'hF : 4'h2;
        end
    end

    // Frame end toggles; cs high clears the shifter, so words are caught here.
    logic [7:0]  op_h_r, data_h_r;
    logic [31:0] addr_h_r;
    logic        fit_h_r, fitd_h_r, quad_h_r, tog_r;
    always_ff @(posedge cs_n_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tog_r    <= 1'b0;
            op_h_r   <= 8'h00;
            data_h_r <= 8'h00;
            addr_h_r <= 32'h0000_0000;
            fit_h_r  <= 1'b0;
            fitd_h_r <= 1'b0;
            quad_h_r <= 1'b0;
        end else begin
            tog_r    <= ~tog_r;
            op_h_r   <= op_r;
            data_h_r <= data_r;
            addr_h_r <= addr_r;
            fit_h_r  <= (bitc_r == 3'd0) &&
                        (bytec_r == 4'd1 + 4'(addr_len(op_r, ext_snap_r)));
            fitd_h_r <= (bitc_r == 3'd0) && (bytec_r == 4'd2);
            quad_h_r <= quad_snap_r;
        end
    end

    // Core domain
    logic [2:0]  tog_sync_r;
    logic [3:0]  io_s1_r;
    logic [3:0]  oe_s1_r;
    fec_state_t  state_r, state_nxt;
    logic        wel_r, wel_nxt;                 
    logic        quad_r, quad_nxt;
    logic        eerr_r, eerr_nxt;
    logic        perr_r, perr_nxt;
    logic [7:0]  sr_r, sr_nxt;
    logic [7:0]  fr_r, fr_nxt;
    fec_req_t    req_r, req_nxt;
    logic [SECT_W:0] sect_r, sect_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [NUM_SECTORS-1:0] blank_r, blank_nxt;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tog_sync_r <= 3'b000;
            io_s1_r    <= 4'h0;
            oe_s1_r    <= 4'h0;
            io_out     <= 4'h0;
            io_oe_out  <= 4'h0;
        end else if (clk_en_in) begin
            tog_sync_r <= {tog_sync_r[1:0], tog_r};
            io_s1_r    <= io_l_r;
            oe_s1_r    <= oe_l_r;
            io_out     <= io_s1_r;
            io_oe_out  <= oe_s1_r;
        end
    end

    logic frame_end;
    logic [7:0] op_c;
    logic       complete_c;
    logic [SECT_W-1:0] base_c;
    logic [SECT_W:0]   span_c;
    always_comb begin
        frame_end  = tog_sync_r[2] ^ tog_sync_r[1];
        op_c       = op_h_r;
        complete_c = fit_h_r;
        state_nxt  = state_r;
        wel_nxt    = wel_r;
        quad_nxt   = quad_r;
        eerr_nxt   = eerr_r;
        perr_nxt   = perr_r;
        sr_nxt     = sr_r;
        fr_nxt     = fr_r;
        req_nxt    = req_r;
        sect_nxt   = sect_r;
        cnt_nxt    = cnt_r;
        blank_nxt  = blank_r;
        base_c     = req_r.addr[SECTOR_SHIFT +: SECT_W];
        span_c     = (SECT_W+1)'(1);
        case (req_r.kind)
            KIND_HALF: begin
                base_c = {base_c[SECT_W-1:3], 3'b000};
                span_c = (SECT_W+1)'(8);
            end
            KIND_FULL: begin
                base_c = {base_c[SECT_W-1:4], 4'b0000};
                span_c = (SECT_W+1)'(16);
            end
            KIND_CHIP: begin
                base_c = '0;
                span_c = (SECT_W+1)'(NUM_SECTORS);
            end
            default: ;
        endcase
        case (state_r)
            FEC_IDLE: begin
                if (frame_end) begin
                    case (op_c)
                        OP_WRITE_ENABLE:
                            if (complete_c) wel_nxt = 1'b1;
                        OP_WRITE_DISABLE:
                            if (complete_c) wel_nxt = 1'b0;
                        OP_STATUS_WRITE:
                            if (wel_r && fitd_h_r) begin
                                sr_nxt  = (sr_r & ~SR_WRITE_MASK) | (data_h_r & SR_WRITE_MASK);
                                wel_nxt = 1'b0;
                            end
                        OP_FUNC_WRITE:
                            if (wel_r && fitd_h_r) begin
                                fr_nxt  = (fr_r & FR_OTP_MASK) | data_h_r;
                                wel_nxt = 1'b0;
                            end
                        OP_QUAD_ENTER:
                            if (complete_c) quad_nxt = 1'b1;
                        OP_QUAD_EXIT:
                            if (complete_c && quad_h_r) quad_nxt = 1'b0;
                        OP_SECTOR_ERASE_A, OP_SECTOR_ERASE_B, OP_SECTOR_ERASE_W,
                        OP_HALF_BLOCK, OP_FULL_BLOCK, OP_HALF_BLOCK_W,
                        OP_FULL_BLOCK_W, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
                            if (complete_c) begin
                                req_nxt.addr = addr_h_r;
                                case (op_c)
                                    OP_HALF_BLOCK, OP_HALF_BLOCK_W: req_nxt.kind = KIND_HALF;
                                    OP_FULL_BLOCK, OP_FULL_BLOCK_W: req_nxt.kind = KIND_FULL;
                                    OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: req_nxt.kind = KIND_CHIP;
                                    default: req_nxt.kind = KIND_SECTOR;
                                endcase
                                state_nxt = FEC_CHECK;
                            end
                        default: ;
                    endcase
                end
            end
            FEC_CHECK: begin
                if (!wel_r) begin
                    state_nxt = FEC_IDLE;
                end else if (req_r.kind == KIND_CHIP &&
                             sr_r[SR_BP_LSB +: 4] != 4'h0) begin
                    eerr_nxt  = 1'b1;
                    perr_nxt  = 1'b1;
                    state_nxt = FEC_REJECT;
                end else begin
                    sect_nxt  = '0;
                    cnt_nxt   = 32'h0000_0000;
                    state_nxt = FEC_WAIT;
                end
            end
            FEC_WAIT: begin
                // Frames during an erase are dropped; status read answers on
                // its own path; suspend and reset are not decoded anywhere.
                if (cnt_r >= ERASE_CYCLES - 1) begin
                    state_nxt = FEC_ERASE;
                end else begin
                    cnt_nxt = cnt_r + 32'd1;
                end
            end
            FEC_ERASE: begin
                if (sect_r == span_c) begin
                    state_nxt = FEC_DONE;
                end else begin
                    if (!(req_r.kind == KIND_CHIP &&
                          asp_protect_in[base_c + sect_r[SECT_W-1:0]])) begin
                        blank_nxt[base_c + sect_r[SECT_W-1:0]] = 1'b1;
                    end
                    sect_nxt = sect_r + (SECT_W+1)'(1);
                end
            end
            FEC_DONE: begin
                wel_nxt   = 1'b0;
                state_nxt = FEC_IDLE;
            end
            FEC_REJECT: begin
                state_nxt = FEC_IDLE;
            end
            default: state_nxt = FEC_IDLE;
        endcase
        sr_nxt[SR_WIP_BIT] = (state_nxt == FEC_WAIT) || (state_nxt == FEC_ERASE) ||
                             (state_nxt == FEC_DONE);
        sr_nxt[SR_WEL_BIT] = wel_nxt;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= FEC_IDLE;
            wel_r   <= 1'b0;
            quad_r  <= 1'b0;
            eerr_r  <= 1'b0;
            perr_r  <= 1'b0;
            sr_r    <= SR_RESET;
            fr_r    <= FR_RESET;
            req_r   <= '0;
            sect_r  <= '0;
            cnt_r   <= 32'h0000_0000;
            blank_r <= '0;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            wel_r   <= wel_nxt;
            quad_r  <= quad_nxt;
            eerr_r  <= eerr_nxt;
            perr_r  <= perr_nxt;
            sr_r    <= sr_nxt;
            fr_r    <= fr_nxt;
            req_r   <= req_nxt;
            sect_r  <= sect_nxt;
            cnt_r   <= cnt_nxt;
            blank_r <= blank_nxt;
        end
    end

    always_comb begin
        write_in_progress_out      = sr_r[SR_WIP_BIT];
        write_enable_latch_out     = wel_r;
        four_wire_command_mode_out = quad_r;
        erase_error_flag_out       = eerr_r;
        protection_error_flag_out  = perr_r;
        status_reg_out             = sr_r;
        function_reg_out           = fr_r;
        sector_blank_out           = blank_r;
    end
endmodule
`default_nettype wire

// file: verification/fec_erase_cmds_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fec_erase_cmds_sva
    import fec_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 5000
) (
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   cs_n_in,
    input wire logic                   write_in_progress_out,
    input wire logic                   write_enable_latch_out,
    input wire logic                   four_wire_command_mode_out,
    input wire logic                   erase_error_flag_out,
    input wire logic                   protection_error_flag_out,
    input wire logic [7:0]             status_reg_out,
    input wire logic [7:0]             function_reg_out,
    input wire logic [NUM_SECTORS-1:0] sector_blank_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_wip_bit; write_in_progress_out == status_reg_out[SR_WIP_BIT]; endproperty
    a_wip_bit: assert property (p_wip_bit) else $error("wip status bit differs");
    property p_wip_wel; $rose(write_in_progress_out) |-> $past(write_enable_latch_out); endproperty
    a_wip_wel: assert property (p_wip_wel) else $error("erase without latch");
    property p_wel_end; $fell(write_in_progress_out) |-> !write_enable_latch_out; endproperty
    a_wel_end: assert property (p_wel_end) else $error("latch kept after erase");
    property p_cs_start; $rose(write_in_progress_out) |-> cs_n_in; endproperty
    a_cs_start: assert property (p_cs_start) else $error("erase began in frame");
    // Erase is long, so a short busy pulse means the count is lost
    property p_wip_hold; $rose(write_in_progress_out) |-> write_in_progress_out [*8]; endproperty
    a_wip_hold: assert property (p_wip_hold) else $error("busy dropped early");
    property p_err_pair; $rose(erase_error_flag_out) |-> protection_error_flag_out; endproperty
    a_err_pair: assert property (p_err_pair) else $error("error flags unpaired");
    property p_err_keep; erase_error_flag_out |=> erase_error_flag_out; endproperty
    a_err_keep: assert property (p_err_keep) else $error("error flag lost");
    property p_otp;
        (($past(function_reg_out) & FR_OTP_MASK) & ~function_reg_out) == 8'h00;
    endproperty
    a_otp: assert property (p_otp) else $error("one-time bit cleared");
    property p_idle_array;
        !write_in_progress_out && !$past(write_in_progress_out) |-> $stable(sector_blank_out);
    endproperty
    a_idle_array: assert property (p_idle_array) else $error("array changed idle");
    c_erase: cover property ($rose(write_in_progress_out));
    c_error: cover property ($rose(erase_error_flag_out));
    c_quad: cover property ($fell(four_wire_command_mode_out));
endmodule
bind fec_erase_cmds fec_erase_cmds_sva #(.ERASE_CYCLES(ERASE_CYCLES)) fec_erase_cmds_sva_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
    .write_in_progress_out(write_in_progress_out),
    .write_enable_latch_out(write_enable_latch_out),
    .four_wire_command_mode_out(four_wire_command_mode_out),
    .erase_error_flag_out(erase_error_flag_out),
    .protection_error_flag_out(protection_error_flag_out),
    .status_reg_out(status_reg_out), .function_reg_out(function_reg_out),
    .sector_blank_out(sector_blank_out)
);
`default_nettype wire

// file: verification/fec_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fec_host_model (
    output logic       sck_out,
    output logic       cs_n_out,
    output logic [3:0] io_out
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        io_out = 4'h0;
    end
    // Mode 0, clock only inside frames
    task automatic xfer(input logic [39:0] d, input int nb, input bit quad);
        int n;
        n = quad ? 2 * nb : 8 * nb;
        #7.3 cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            if (quad) io_out = d[4*i +: 4];
            else io_out[0] = d[i];
            #15 sck_out = 1'b1;
            #15 sck_out = 1'b0;
        end
        #15 cs_n_out = 1'b1;
        // Released lines must not hold the last bit
        io_out = ~io_out;
        #60;
    endtask
endmodule
`default_nettype wire

// file: verification/fec_erase_cmds_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fec_erase_cmds_bench
    import fec_pkg::*;
;
    logic                   clk_in = 1'b0;
    logic                   rst_n_in = 1'b0;
    logic                   ext = 1'b0;
    logic                   sck, cs_n, write_in_progress, write_enable_latch, quad, e_err, p_err;
    logic [3:0]             io, dout, oe;
    logic [7:0]             sr, fr;
    logic [NUM_SECTORS-1:0] advanced_sector_protection = '0;
    logic [NUM_SECTORS-1:0] blank;
    logic [NUM_SECTORS-1:0] exp_blank = '0;
    int                     err_count = 0;
    int                     n_tests = 0;
    always #4 clk_in = ~clk_in;
    fec_host_model host_i (.sck_out(sck), .cs_n_out(cs_n), .io_out(io));
    fec_erase_cmds #(.ERASE_CYCLES(200)) fec_erase_cmds_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .sck_in(sck),
        .cs_n_in(cs_n), .io_in(io), .io_out(dout), .io_oe_out(oe),
        .extended_addressing_in(ext), .asp_protect_in(advanced_sector_protection),
        .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch),
        .four_wire_command_mode_out(quad), .erase_error_flag_out(e_err),
        .protection_error_flag_out(p_err), .status_reg_out(sr),
        .function_reg_out(fr), .sector_blank_out(blank)
    );
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] a = 0, input int nab = 0);
        logic [39:0] d;
        d = {32'h0, op};
        for (int i = nab - 1; i >= 0; i--) d = {d[31:0], a[8*i +: 8]};
        host_i.xfer(d, nab + 1, 1'b0);
        repeat (4) @(negedge clk_in);
    endtask
    task automatic erase(input logic [7:0] op, input logic e, input int nab,
                         input logic [31:0] a, input int lo, input int cnt);
        int k;
        @(negedge clk_in);
        ext = e;
        cmd(OP_WRITE_ENABLE);
        cmd(op, a, nab);
        check("busy", write_in_progress, 1);
        cmd(OP_WRITE_DISABLE);
        check("ignored in erase", write_enable_latch, 1);
        check("status busy", sr[SR_WIP_BIT], 1);
        for (k = 0; k < 20000 && write_in_progress !== 1'b0; k++) @(negedge clk_in);
        if (k == 20000) begin
            check("erase timeout", 1, 0);
            test_done();
        end
        for (int i = lo; i < lo + cnt; i++) exp_blank[i] = 1'b1;
        check("wel after erase", write_enable_latch, 0);
        check("array", blank === exp_blank, 1);
    endtask
    task automatic t_wel();
        check("wel at reset", write_enable_latch, 0);
        cmd(OP_WRITE_ENABLE);
        check("wel set", write_enable_latch, 1);
        cmd(OP_WRITE_DISABLE);
        check("wel clear", write_enable_latch, 0);
        cmd(OP_SECTOR_ERASE_B, 32'h0000_1000, 3);
        check("no wel busy", write_in_progress, 0);
        check("no wel array", |blank, 0);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_SECTOR_ERASE_B, 32'h0000_1000, 2);
        check("short frame", write_in_progress, 0);
    endtask
    task automatic t_regs();
        cmd(OP_WRITE_ENABLE);
        cmd(OP_STATUS_WRITE, 32'h0000_0004, 1);
        check("protect bits", sr[5:2], 4'h1);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_CHIP_ERASE_B);
        check("chip refused", write_in_progress, 0);
        check("both errors", {e_err, p_err}, 2'b11);
        check("array kept", blank === exp_blank, 1);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_FUNC_WRITE, 32'h0000_0011, 1);
        check("function set", fr, 8'h11);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_FUNC_WRITE, 32'h0000_0000, 1);
        check("function kept", fr, 8'h11);
    endtask
    task automatic t_quad();
        cmd(OP_QUAD_ENTER);
        check("quad on", quad, 1);
        cmd(OP_QUAD_EXIT);
        check("eight clock exit", quad, 1);
        host_i.xfer({32'h0, OP_QUAD_EXIT}, 1, 1'b1);
        repeat (4) @(negedge clk_in);
        check("quad off", quad, 0);
        check("lines released", {oe, dout}, 8'h00);
    endtask
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_wel();
        erase(OP_SECTOR_ERASE_B, 0, 3, 32'h0000_3000, 3, 1);
        erase(OP_SECTOR_ERASE_A, 1, 4, 32'h0000_5000, 5, 1);
        erase(OP_SECTOR_ERASE_W, 0, 4, 32'h0000_6FFF, 6, 1);
        erase(OP_HALF_BLOCK, 0, 3, 32'h0001_0000, 16, 8);
        erase(OP_FULL_BLOCK, 1, 4, 32'h0002_0000, 32, 16);
        erase(OP_HALF_BLOCK_W, 0, 4, 32'h0003_8000, 56, 8);
        erase(OP_FULL_BLOCK_W, 0, 4, 32'h0004_0000, 64, 16);
        advanced_sector_protection[0] = 1'b1;
        erase(OP_CHIP_ERASE_A, 0, 0, 32'h0, 1, NUM_SECTORS - 1);
        check("no error flags", {e_err, p_err}, 2'b00);
        t_regs();
        t_quad();
        test_done();
    end
endmodule
`default_nettype wire
